// file: vrl_pkg.sv
// Purpose: Constants for the voltage reference and supply drop detector control block
// Assumes: AXI4-Lite register access, 32-bit data, 25 MHz clock
// Notes:   Register offsets are local choices, fixed by this block alone
`default_nettype none

package vrl_pkg;
    // Register byte offsets
    localparam logic [3:0] OFF_DET_CTRL = 4'h0;
    localparam logic [3:0] OFF_REF_CTRL = 4'h4;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h8;
    localparam logic [3:0] OFF_IRQ_EN   = 4'hC;
    localparam logic [3:0] OFF_IRQ_CLR  = 4'h0; // Clear sits in upper window, see ADDR bit 4
    localparam logic [4:0] OFF_IRQ_CLRW = 5'h10;
    // Detector control fields
    localparam int DET_STABLE_BIT = 5;
    localparam int DET_EN_BIT     = 4;
    localparam logic [3:0] TRIP_RESET    = 4'h5;
    localparam logic [3:0] TRIP_EXTERNAL = 4'hF;
    // Reference control fields
    localparam int REF_HI_EN_BIT  = 7;
    localparam int REF_LO_EN_BIT  = 6;
    localparam int REF_HI_OE_BIT  = 5;
    localparam int REF_LO_OE_BIT  = 4;
    // Interrupt status bits
    localparam int IRQ_STABLE_BIT = 0;
    localparam int IRQ_LOST_BIT   = 1;
    localparam int IRQ_W          = 2;
    // Bandgap start-up time: 50 us at 25 MHz
    localparam int STARTUP_US     = 50;
    localparam int CLK_MHZ        = 25;
    localparam int STARTUP_CYCLES = STARTUP_US * CLK_MHZ;
    localparam int CNT_W          = 12;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

`default_nettype wire

// file: vrl_ctrl.sv
// Purpose: Control and status registers of the voltage reference / supply drop detector
// Assumes: AXI4-Lite slave, one clock, synchronous active-low reset
// Notes:   Analog parts sit outside; this block drives their enables
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`default_nettype none

module vrl_ctrl #(
    parameter int unsigned STARTUP_CYCLES = vrl_pkg::STARTUP_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        brownout_reset_en,
    output var  logic        bandgap_enable,
    output var  logic        detector_enable,
    output var  logic [3:0]  trip_select,
    output var  logic        trip_external,
    output var  logic        high_ref_enable,
    output var  logic        low_ref_enable,
    output var  logic        high_ref_pin_drive,
    output var  logic        port_a_pin_two_ref,
    output var  logic        irq
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic        bor_s1;
        logic        bor_s2;
        logic        awdone;
        logic [4:0]  awaddr;
        logic        wdone;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        det_en;
        logic [3:0]  trip;
        logic        hi_en;
        logic        lo_en;
        logic        hi_oe;
        logic        lo_oe;
        logic        bg_en;
        logic        stable;
        logic [vrl_pkg::CNT_W-1:0] cnt;
        logic [vrl_pkg::IRQ_W-1:0] stat;
        logic [vrl_pkg::IRQ_W-1:0] ien;
        logic        det_out;
        logic [3:0]  trip_out;
        logic        trip_ext;
        logic        hi_out;
        logic        lo_out;
        logic        hi_pin;
        logic        lo_pin;
        logic        irq;
    } vrl_state_t;

    vrl_state_t cur_ff;
    vrl_state_t nxt_st;

    logic       bg_need;
    logic       wr_go;
    logic       rd_go;
    logic [7:0] det_rd;
    logic [7:0] ref_rd;
    logic [vrl_pkg::IRQ_W-1:0] evt;

    ////////////////////////////////////////////////////////////////////////////
    // Register read views
    always_comb begin
        det_rd = {2'h0, cur_ff.stable, cur_ff.det_en, cur_ff.trip};
        ref_rd = {cur_ff.hi_en, cur_ff.lo_en, cur_ff.hi_oe, cur_ff.lo_oe, 4'h0};
        // Any user keeps the bandgap alive
        bg_need = cur_ff.bor_s2 | cur_ff.det_en | cur_ff.hi_en | cur_ff.lo_en;
        wr_go = cur_ff.awdone & cur_ff.wdone & ~cur_ff.bvalid;
        rd_go = s_axi_arvalid & ~cur_ff.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        nxt_st = cur_ff;
        // Strap from another domain, two flops before use
        nxt_st.bor_s1 = brownout_reset_en;
        nxt_st.bor_s2 = cur_ff.bor_s1;

        // Write address and data captured independently
        if (s_axi_awvalid && !cur_ff.awdone) begin
            nxt_st.awdone = 1'b1;
            nxt_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !cur_ff.wdone) begin
            nxt_st.wdone = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (s_axi_bready && cur_ff.bvalid) begin
            nxt_st.bvalid = 1'b0;
        end

        // Bandgap follows its users; start-up counter gates stable
        nxt_st.bg_en = bg_need;
        if (!bg_need) begin
            nxt_st.stable = 1'b0;
            nxt_st.cnt    = '0;
        end else if (!cur_ff.stable) begin
            if (cur_ff.cnt >= vrl_pkg::CNT_W'(STARTUP_CYCLES - 1)) begin
                nxt_st.stable = 1'b1;
            end else begin
                nxt_st.cnt = cur_ff.cnt + 1'b1;
            end
        end

        // Events: stable gained, stable lost; kept apart so a clear cannot eat them
        evt = '0;
        if (!cur_ff.stable && nxt_st.stable) begin
            evt[vrl_pkg::IRQ_STABLE_BIT] = 1'b1;
        end
        if (cur_ff.stable && !nxt_st.stable) begin
            evt[vrl_pkg::IRQ_LOST_BIT] = 1'b1;
        end
        nxt_st.stat = cur_ff.stat | evt;

        // Register write; clear loses to a same-cycle set
        if (wr_go) begin
            nxt_st.awdone = 1'b0;
            nxt_st.wdone  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = vrl_pkg::RESP_OKAY;
            if (cur_ff.wstrb[0]) begin
                case (cur_ff.awaddr)
                    {1'b0, vrl_pkg::OFF_DET_CTRL}: begin
                        nxt_st.det_en = cur_ff.wdata[vrl_pkg::DET_EN_BIT];
                        nxt_st.trip   = cur_ff.wdata[3:0];
                    end
                    {1'b0, vrl_pkg::OFF_REF_CTRL}: begin
                        nxt_st.hi_en = cur_ff.wdata[vrl_pkg::REF_HI_EN_BIT];
                        nxt_st.lo_en = cur_ff.wdata[vrl_pkg::REF_LO_EN_BIT];
                        nxt_st.hi_oe = cur_ff.wdata[vrl_pkg::REF_HI_OE_BIT];
                        nxt_st.lo_oe = cur_ff.wdata[vrl_pkg::REF_LO_OE_BIT];
                    end
                    {1'b0, vrl_pkg::OFF_IRQ_EN}: begin
                        nxt_st.ien = cur_ff.wdata[vrl_pkg::IRQ_W-1:0];
                    end
                    vrl_pkg::OFF_IRQ_CLRW: begin
                        nxt_st.stat = (cur_ff.stat & ~cur_ff.wdata[vrl_pkg::IRQ_W-1:0]) | evt;
                    end
                    {1'b0, vrl_pkg::OFF_IRQ_STAT}: begin
                    end
                    default: begin
                        nxt_st.bresp = vrl_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end

        // Register read
        if (s_axi_rready && cur_ff.rvalid) begin
            nxt_st.rvalid = 1'b0;
        end
        if (rd_go) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = vrl_pkg::RESP_OKAY;
            case (s_axi_araddr)
                {1'b0, vrl_pkg::OFF_DET_CTRL}: nxt_st.rdata = {24'h000000, det_rd};
                {1'b0, vrl_pkg::OFF_REF_CTRL}: nxt_st.rdata = {24'h000000, ref_rd};
                {1'b0, vrl_pkg::OFF_IRQ_STAT}: nxt_st.rdata = {30'h00000000, cur_ff.stat};
                {1'b0, vrl_pkg::OFF_IRQ_EN}:   nxt_st.rdata = {30'h00000000, cur_ff.ien};
                vrl_pkg::OFF_IRQ_CLRW:         nxt_st.rdata = 32'h00000000;
                default: begin
                    nxt_st.rdata = 32'h00000000;
                    nxt_st.rresp = vrl_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Registered outputs to the analog side
        nxt_st.det_out  = cur_ff.det_en;
        nxt_st.trip_out = cur_ff.trip;
        nxt_st.trip_ext = (cur_ff.trip == vrl_pkg::TRIP_EXTERNAL);
        nxt_st.hi_out   = cur_ff.hi_en;
        nxt_st.lo_out   = cur_ff.lo_en;
        // Pin routing needs the reference itself running
        nxt_st.hi_pin   = cur_ff.hi_oe & cur_ff.hi_en;
        nxt_st.lo_pin   = cur_ff.lo_oe & cur_ff.lo_en;
        nxt_st.irq      = |(nxt_st.stat & cur_ff.ien);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cur_ff      <= '0;
            cur_ff.trip <= vrl_pkg::TRIP_RESET;
            cur_ff.trip_out <= vrl_pkg::TRIP_RESET;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    assign s_axi_awready      = ~cur_ff.awdone;
    assign s_axi_wready       = ~cur_ff.wdone;
    assign s_axi_bvalid       = cur_ff.bvalid;
    assign s_axi_bresp        = cur_ff.bresp;
    assign s_axi_arready      = ~cur_ff.rvalid;
    assign s_axi_rvalid       = cur_ff.rvalid;
    assign s_axi_rdata        = cur_ff.rdata;
    assign s_axi_rresp        = cur_ff.rresp;
    assign bandgap_enable     = cur_ff.bg_en;
    assign detector_enable    = cur_ff.det_out;
    assign trip_select        = cur_ff.trip_out;
    assign trip_external      = cur_ff.trip_ext;
    assign high_ref_enable    = cur_ff.hi_out;
    assign low_ref_enable     = cur_ff.lo_out;
    assign high_ref_pin_drive = cur_ff.hi_pin;
    assign port_a_pin_two_ref = cur_ff.lo_pin;
    assign irq                = cur_ff.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_bg_or;
        @(posedge clk_sys) disable iff (!rst_n)
        ##1 bandgap_enable == $past(bg_need);
    endproperty
    a_bg_or: assert property (p_bg_or) else $error("bandgap enable not OR of users");

    property p_bg_off;
        @(posedge clk_sys) disable iff (!rst_n)
        (!cur_ff.bor_s2 && !cur_ff.det_en && !cur_ff.hi_en && !cur_ff.lo_en) |=> !bandgap_enable;
    endproperty
    a_bg_off: assert property (p_bg_off) else $error("bandgap left on with no user");

    property p_stable_clear;
        @(posedge clk_sys) disable iff (!rst_n)
        !bandgap_enable |-> !cur_ff.stable;
    endproperty
    a_stable_clear: assert property (p_stable_clear) else $error("stable set with bandgap off");

    property p_stable_rise;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(cur_ff.stable) |-> cur_ff.cnt == vrl_pkg::CNT_W'(STARTUP_CYCLES - 1);
    endproperty
    a_stable_rise: assert property (p_stable_rise) else $error("stable set before start-up");

    property p_lo_pin;
        @(posedge clk_sys) disable iff (!rst_n)
        port_a_pin_two_ref |-> $past(cur_ff.lo_en) && $past(cur_ff.lo_oe);
    endproperty
    a_lo_pin: assert property (p_lo_pin) else $error("low reference on pin while off");

    property p_hi_pin;
        @(posedge clk_sys) disable iff (!rst_n)
        high_ref_pin_drive |-> $past(cur_ff.hi_en);
    endproperty
    a_hi_pin: assert property (p_hi_pin) else $error("high pin driven while off");

    property p_ext;
        @(posedge clk_sys) disable iff (!rst_n)
        trip_external == ($past(cur_ff.trip) == vrl_pkg::TRIP_EXTERNAL);
    endproperty
    a_ext: assert property (p_ext) else $error("external trip mismatch");

    property p_ref_low;
        @(posedge clk_sys) disable iff (!rst_n)
        (rd_go && s_axi_araddr == {1'b0, vrl_pkg::OFF_REF_CTRL}) |=> s_axi_rdata[3:0] == 4'h0;
    endproperty
    a_ref_low: assert property (p_ref_low) else $error("reference low bits not zero");

    property p_det_top;
        @(posedge clk_sys) disable iff (!rst_n)
        (rd_go && s_axi_araddr == {1'b0, vrl_pkg::OFF_DET_CTRL}) |=> s_axi_rdata[7:6] == 2'h0;
    endproperty
    a_det_top: assert property (p_det_top) else $error("detector top bits not zero");

    property p_det_wr;
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_go && cur_ff.wstrb[0] && cur_ff.awaddr == {1'b0, vrl_pkg::OFF_DET_CTRL})
            |=> cur_ff.det_en == $past(cur_ff.wdata[vrl_pkg::DET_EN_BIT]) ##1 bandgap_enable || cur_ff.bor_s2
                || !cur_ff.det_en;
    endproperty
    a_det_wr: assert property (p_det_wr) else $error("detector enable write lost");

    property p_set_wins;
        @(posedge clk_sys) disable iff (!rst_n)
        (evt != '0) |=> (cur_ff.stat & $past(evt)) == $past(evt);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("status event lost to a clear");

    property p_stable_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        (cur_ff.stable && bg_need) |=> cur_ff.stable;
    endproperty
    a_stable_hold: assert property (p_stable_hold) else $error("stable dropped while powered");

    property p_irq;
        @(posedge clk_sys) disable iff (!rst_n)
        ##1 irq == |(cur_ff.stat & $past(cur_ff.ien));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");

    property p_det_mirror;
        @(posedge clk_sys) disable iff (!rst_n)
        ##1 detector_enable == $past(cur_ff.det_en);
    endproperty
    a_det_mirror: assert property (p_det_mirror) else $error("detector enable mirror wrong");

    property p_trip_mirror;
        @(posedge clk_sys) disable iff (!rst_n)
        ##1 trip_select == $past(cur_ff.trip);
    endproperty
    a_trip_mirror: assert property (p_trip_mirror) else $error("trip select mirror wrong");

    property p_ref_mirror;
        @(posedge clk_sys) disable iff (!rst_n)
        ##1 high_ref_enable == $past(cur_ff.hi_en) && low_ref_enable == $past(cur_ff.lo_en);
    endproperty
    a_ref_mirror: assert property (p_ref_mirror) else $error("reference enable mirror wrong");

    c_stable: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(cur_ff.stable));
    c_irq:    cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(irq));
    c_pin:    cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(port_a_pin_two_ref));
    c_clear:  cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(irq));
    c_ext:    cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(trip_external));

endmodule

`default_nettype wire

// file: vrl_ctrl_tb.sv
// Purpose: Self-checking bench for the voltage reference control block
// Assumes: AXI4-Lite master tasks, 25 MHz clock, short bandgap start-up count
// Notes:   Start-up count cut to 4 so the stable flag appears quickly
`default_nettype none

module vrl_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STARTUP = 4;

    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic        brownout_reset_en = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        bandgap_enable, detector_enable, trip_external, high_ref_enable, low_ref_enable;
    logic        high_ref_pin_drive, port_a_pin_two_ref, irq;
    logic [3:0]  trip_select;
    int          errors = 0;
    int          checked = 0;
    logic [31:0] rd;
    logic [1:0]  rsp;
    logic [7:0]  trip_tab [6] = '{8'h07, 8'h06, 8'h05, 8'hCF, 8'h24, 8'h04};
    logic [7:0]  ref_tab [6]  = '{8'hFF, 8'h30, 8'hA0, 8'h50, 8'h40, 8'h00};

    vrl_ctrl #(.STARTUP_CYCLES(STARTUP)) i_vrl_ctrl (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .brownout_reset_en(brownout_reset_en), .bandgap_enable(bandgap_enable),
        .detector_enable(detector_enable), .trip_select(trip_select), .trip_external(trip_external),
        .high_ref_enable(high_ref_enable), .low_ref_enable(low_ref_enable),
        .high_ref_pin_drive(high_ref_pin_drive), .port_a_pin_two_ref(port_a_pin_two_ref), .irq(irq)
    );

    // 40 ns period
    always begin
        #20 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Bus tasks; entered just after a rising edge, each channel held until taken
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 200);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
        if (n >= 200) chk(32'h0, 32'h1);
    endtask

    task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 200);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
        if (n >= 200) chk(32'h0, 32'h1);
    endtask

    // Write expecting OKAY, then let the mirrors settle
    task automatic wr_ok(input logic [4:0] a, input logic [31:0] d);
        axi_wr(a, d, rsp);
        chk(rsp, vrl_pkg::RESP_OKAY);
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        axi_rd(a, rd, rsp);
        chk(rd, exp);
        chk(rsp, vrl_pkg::RESP_OKAY);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: whole sequence needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        results();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd_chk({1'b0, vrl_pkg::OFF_DET_CTRL}, 32'h0000_0005);
        rd_chk({1'b0, vrl_pkg::OFF_REF_CTRL}, 32'h0000_0000);
        chk(bandgap_enable, 1'b0);
        chk(trip_select, vrl_pkg::TRIP_RESET);
        // Trip codes, reserved high bits and read-only stable bit
        foreach (trip_tab[i]) begin
            wr_ok({1'b0, vrl_pkg::OFF_DET_CTRL}, {24'h0, trip_tab[i]});
            chk(trip_select, trip_tab[i][3:0]);
            chk(trip_external, trip_tab[i][3:0] == 4'hF);
            chk(bandgap_enable, 1'b0);
            rd_chk({1'b0, vrl_pkg::OFF_DET_CTRL}, {24'h0, trip_tab[i] & 8'h1F});
        end
        // Reference enables, output routing and bandgap sharing
        foreach (ref_tab[i]) begin
            wr_ok({1'b0, vrl_pkg::OFF_REF_CTRL}, {24'h0, ref_tab[i]});
            chk(high_ref_enable, ref_tab[i][7]);
            chk(low_ref_enable, ref_tab[i][6]);
            chk(high_ref_pin_drive, ref_tab[i][7] & ref_tab[i][5]);
            chk(port_a_pin_two_ref, ref_tab[i][6] & ref_tab[i][4]);
            chk(bandgap_enable, ref_tab[i][7] | ref_tab[i][6]);
            rd_chk({1'b0, vrl_pkg::OFF_REF_CTRL}, {24'h0, ref_tab[i] & 8'hF0});
        end
        // Brown-out user alone powers the bandgap
        brownout_reset_en <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk(bandgap_enable, 1'b1);
        brownout_reset_en <= 1'b0;
        repeat (5) @(posedge clk_sys);
        chk(bandgap_enable, 1'b0);
        // Reference and brown-out runs both gained and lost stability
        rd_chk({1'b0, vrl_pkg::OFF_IRQ_STAT}, 32'h0000_0003);
        wr_ok(vrl_pkg::OFF_IRQ_CLRW, 32'h0000_0003);
        rd_chk({1'b0, vrl_pkg::OFF_IRQ_STAT}, 32'h0000_0000);
        // Detector on, stable flag after start-up, stable event interrupt
        wr_ok({1'b0, vrl_pkg::OFF_DET_CTRL}, 32'h0000_0015);
        chk(detector_enable, 1'b1);
        chk(bandgap_enable, 1'b1);
        repeat (STARTUP + 4) @(posedge clk_sys);
        rd_chk({1'b0, vrl_pkg::OFF_DET_CTRL}, 32'h0000_0035);
        rd_chk({1'b0, vrl_pkg::OFF_IRQ_STAT}, 32'h0000_0001);
        chk(irq, 1'b0);
        wr_ok({1'b0, vrl_pkg::OFF_IRQ_EN}, 32'h0000_0001);
        chk(irq, 1'b1);
        wr_ok(vrl_pkg::OFF_IRQ_CLRW, 32'h0000_0001);
        chk(irq, 1'b0);
        rd_chk({1'b0, vrl_pkg::OFF_IRQ_STAT}, 32'h0000_0000);
        rd_chk(vrl_pkg::OFF_IRQ_CLRW, 32'h0000_0000);
        // Last user off: bandgap off, stable cleared, loss event masked then enabled
        wr_ok({1'b0, vrl_pkg::OFF_DET_CTRL}, 32'h0000_0005);
        chk(bandgap_enable, 1'b0);
        rd_chk({1'b0, vrl_pkg::OFF_DET_CTRL}, 32'h0000_0005);
        rd_chk({1'b0, vrl_pkg::OFF_IRQ_STAT}, 32'h0000_0002);
        chk(irq, 1'b0);
        wr_ok({1'b0, vrl_pkg::OFF_IRQ_EN}, 32'h0000_0003);
        chk(irq, 1'b1);
        wr_ok(vrl_pkg::OFF_IRQ_CLRW, 32'h0000_0002);
        chk(irq, 1'b0);
        // Unmapped addresses answer with an error and zero data
        axi_rd(5'h14, rd, rsp);
        chk(rd, 32'h0000_0000);
        chk(rsp, vrl_pkg::RESP_SLVERR);
        axi_wr(5'h18, 32'hFFFF_FFFF, rsp);
        chk(rsp, vrl_pkg::RESP_SLVERR);
        @(posedge clk_sys);
        results();
    end
endmodule

`default_nettype wire
